// *** bench/wdtc_watchdog_monitor.sv ***
`timescale 1ns/1ps
`include "wdtc_params.svh"

module wdtc_watchdog_monitor
  import wdtc_pkg::*;
#(
  parameter int unsigned MISS_CYCLES = 20
)
(
  input wire logic                    clk_sys_i,
  input wire logic                    rst_i,
  input wire logic [`WDTC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`WDTC_DATA_W-1:0] reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [`WDTC_DATA_W-1:0] reg_rdata_o,
  input wire logic                    clear_watchdog_instr_i,
  input wire logic                    power_save_instr_i,
  input wire logic                    wake_resume_i,
  input wire logic                    osc_switch_done_i,
  input wire logic                    low_power_rc_osc_i,
  input wire logic                    rc_osc_enable_o,
  input wire logic                    timeout_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Read data must not linger, software may poll without strobes
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read slot");
  timeout_pulse_a: assert property (timeout_o |=> !timeout_o)
    else $error("timeout longer than one cycle");
  osc_enable_a: assert property (reg_wr_i && reg_addr_i == `WDTC_OFF_CTRL
    |=> rc_osc_enable_o == $past(reg_wdata_i[`WDTC_CTRL_EN]))
    else $error("oscillator enable not taken from write");
  osc_hold_a: assert property (!(reg_wr_i && reg_addr_i == `WDTC_OFF_CTRL)
    |=> $stable(rc_osc_enable_o))
    else $error("oscillator enable moved without write");
  switch_clear_a: assert property (osc_switch_done_i
    |=> !timeout_o [*2])
    else $error("timeout right after clock switch");
  disabled_quiet_a: assert property (!rc_osc_enable_o [*2]
    |=> !timeout_o)
    else $error("timeout while disabled");
  read_ctrl_a: assert property (reg_rd_i && reg_addr_i == `WDTC_OFF_CTRL
    |=> reg_rdata_o[0] == $past(rc_osc_enable_o))
    else $error("control read disagrees with enable");
  unmapped_read_a: assert property (reg_rd_i
    && reg_addr_i > `WDTC_OFF_POST_TERM |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  // Without RC edges the chain cannot step, whatever the system clock does
  rc_only_a: assert property (!low_power_rc_osc_i [*8] |-> !timeout_o)
    else $error("timeout without oscillator edge");
endmodule : wdtc_watchdog_monitor

bind wdtc_watchdog wdtc_watchdog_monitor #(.MISS_CYCLES(MISS_CYCLES)) u_mon (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .clear_watchdog_instr_i(clear_watchdog_instr_i),
  .power_save_instr_i(power_save_instr_i), .wake_resume_i(wake_resume_i),
  .osc_switch_done_i(osc_switch_done_i),
  .low_power_rc_osc_i(low_power_rc_osc_i),
  .rc_osc_enable_o(rc_osc_enable_o), .timeout_o(timeout_o)
);

// *** bench/wdtc_watchdog_tb.sv ***
`timescale 1ns/1ps
`include "wdtc_params.svh"

module wdtc_watchdog_tb
  import wdtc_pkg::*;
;
  logic        clk, rst, rc, wr, rd, osc_en, tmo;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  ev;
  int          n_errors, tests_run, n_to;
  logic [3:0]  evs [3] = '{4'h2, 4'h4, 4'h8};

  // Short stall limit keeps the stall watch inside a short run
  wdtc_watchdog #(.MISS_CYCLES(20)) uut (
    .clk_sys_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .clear_watchdog_instr_i(ev[0]), .power_save_instr_i(ev[1]),
    .wake_resume_i(ev[2]), .osc_switch_done_i(ev[3]),
    .low_power_rc_osc_i(rc), .rc_osc_enable_o(osc_en), .timeout_o(tmo)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) if (tmo === 1'b1) n_to <= n_to + 1;

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask : rd_reg

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, d);
    chk(d, e);
  endtask : rd_chk

  task fire(input logic [3:0] m);
    @(posedge clk); ev <= m;
    @(posedge clk); ev <= 4'h0;
  endtask : fire

  // RC edges come far faster than nominal so a timeout fits in the run
  task rcs(input int n);
    repeat (n) begin
      @(posedge clk); rc <= 1'b1;
      repeat (4) @(posedge clk);
      rc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : rcs

  task conclude;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    rst = 1'b1; rc = 1'b0; wr = 1'b0; rd = 1'b0; ev = 4'h0;
    addr = 8'h00; wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`WDTC_OFF_CTRL, 32'h0);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h0);
    rd_chk(`WDTC_OFF_POST_COUNT, 32'h0);
    chk(osc_en, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      wr_reg(`WDTC_OFF_CTRL, 32'(n) << 2);
      rd_chk(`WDTC_OFF_POST_TERM, (32'h1 << n) - 32'h1);
    end
    rd_chk(`WDTC_OFF_POST_TERM, 32'h7FFF);
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    $display("test postscale done");
    wr_reg(`WDTC_OFF_CTRL, 32'h5);
    @(negedge clk) chk(osc_en, 32'h1);
    rcs(10);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'hA);
    repeat (40) @(posedge clk);
    rd_chk(`WDTC_OFF_STATUS, 32'h6);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'hA);
    fire(4'h1);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h0);
    rcs(63);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h1F);
    rd_chk(`WDTC_OFF_POST_COUNT, 32'h1);
    chk(n_to, 32'h0);
    rcs(1);
    rd_reg(`WDTC_OFF_STATUS, d);
    chk(d[0], 32'h1);
    chk(n_to, 32'h1);
    wr_reg(`WDTC_OFF_STATUS, 32'h1);
    rd_reg(`WDTC_OFF_STATUS, d);
    chk(d[0], 32'h0);
    $display("test timeout done");
    foreach (evs[i]) begin
      rcs(5);
      fire(evs[i]);
      rd_chk(`WDTC_OFF_PRE_COUNT, 32'h0);
    end
    fire(4'h2);
    rcs(3);
    fire(4'h1);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h3);
    rd_chk(`WDTC_OFF_STATUS, 32'h8);
    fire(4'h4);
    rd_chk(`WDTC_OFF_STATUS, 32'h4);
    $display("test clears done");
    wr_reg(`WDTC_OFF_CTRL, 32'h3);
    rcs(127);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h7F);
    chk(n_to, 32'h1);
    rcs(1);
    @(negedge clk) chk(n_to, 32'h2);
    $display("test long prescale done");
    rcs(5);
    wr_reg(`WDTC_OFF_CTRL, 32'h2);
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h0);
    chk(osc_en, 32'h0);
    wr_reg(`WDTC_OFF_CTRL, 32'h3);
    rcs(5);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`WDTC_OFF_PRE_COUNT, 32'h0);
    rd_chk(`WDTC_OFF_CTRL, 32'h0);
    chk(osc_en, 32'h0);
    $display("test mid reset done");
    conclude();
  end
endmodule : wdtc_watchdog_tb

// *** design/wdtc_params.svh ***
`ifndef WDTC_PARAMS_SVH
`define WDTC_PARAMS_SVH

// Register bus
`define WDTC_ADDR_W         8
`define WDTC_DATA_W         32
`define WDTC_OFF_CTRL       8'h00
`define WDTC_OFF_STATUS     8'h04
`define WDTC_OFF_PRE_COUNT  8'h08
`define WDTC_OFF_POST_COUNT 8'h0C
`define WDTC_OFF_POST_TERM  8'h10

// Control register fields
`define WDTC_CTRL_EN        0
`define WDTC_CTRL_PSA       1
`define WDTC_CTRL_PS_LSB    2
`define WDTC_CTRL_PS_MSB    5
`define WDTC_CTRL_W         6
`define WDTC_CTRL_RST       6'h00

// Status register fields
`define WDTC_STAT_TIMEOUT   0
`define WDTC_STAT_RC_STALL  1
`define WDTC_STAT_RUNNING   2
`define WDTC_STAT_SLEEP     3

// Prescaler and postscaler
`define WDTC_PRE_W          7
`define WDTC_PRE_SHORT      32
`define WDTC_PRE_LONG       128
`define WDTC_POST_W         15
`define WDTC_PS_W           4

// Timing
`define WDTC_SYS_HZ         40000000
`define WDTC_LOW_POWER_RC_OSC_HZ        31000
`define WDTC_MISS_PERIODS   4

`endif

// *** design/wdtc_pkg.sv ***
`include "wdtc_params.svh"

package wdtc_pkg;

  typedef enum logic [1:0] {
    WDTC_OFF   = 2'h0,
    WDTC_RUN   = 2'h1,
    WDTC_SLEEP = 2'h3
  } wdtc_state_e;

  typedef logic [`WDTC_POST_W-1:0] wdtc_post_t;

  // Terminal count of the postscaler: ratio 2**code, last count 2**code-1
  function automatic wdtc_post_t wdtc_post_limit(
    input logic [`WDTC_PS_W-1:0] code
  );
    logic [`WDTC_POST_W:0] one_hot;
    one_hot = (`WDTC_POST_W+1)'(1) << code;
    return wdtc_post_t'(one_hot - (`WDTC_POST_W+1)'(1));
  endfunction : wdtc_post_limit

endpackage : wdtc_pkg

// *** design/wdtc_postscaler.sv ***
`timescale 1ns/1ps
`include "wdtc_params.svh"

module wdtc_postscaler
  import wdtc_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   advance_i,
  input  wire logic                   clear_i,
  input  wire logic [`WDTC_PS_W-1:0]  sel_i,
  output logic                        expire_o,
  output logic [`WDTC_POST_W-1:0]     count_o
);

  wdtc_post_t cnt_r;
  wdtc_post_t cnt_nxt;
  wdtc_post_t last;

  always_comb begin
    last     = wdtc_post_limit(sel_i);                         // [R8]
    expire_o = advance_i && !clear_i && (cnt_r >= last);       // [R6]
    cnt_nxt  = cnt_r;
    if (clear_i) begin
      cnt_nxt = '0;
    end else if (advance_i) begin
      cnt_nxt = (cnt_r >= last) ? '0 : cnt_r + `WDTC_POST_W'(1); // [R7]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;                                              // [R9]
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;

endmodule : wdtc_postscaler

// *** design/wdtc_prescaler.sv ***
`timescale 1ns/1ps
`include "wdtc_params.svh"

module wdtc_prescaler
  import wdtc_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   advance_i,
  input  wire logic                   clear_i,
  input  wire logic                   long_sel_i,
  output logic                        tick_o,
  output logic [`WDTC_PRE_W-1:0]      count_o
);

  logic [`WDTC_PRE_W-1:0] cnt_r;
  logic [`WDTC_PRE_W-1:0] cnt_nxt;
  logic [`WDTC_PRE_W-1:0] last;

  always_comb begin
    last = long_sel_i ? `WDTC_PRE_W'(`WDTC_PRE_LONG - 1)
                      : `WDTC_PRE_W'(`WDTC_PRE_SHORT - 1);   // [R4]
    tick_o  = advance_i && !clear_i && (cnt_r >= last);
    cnt_nxt = cnt_r;
    if (clear_i) begin
      cnt_nxt = '0;
    end else if (advance_i) begin
      // Wraps also when the divider was shortened mid-count
      cnt_nxt = (cnt_r >= last) ? '0 : cnt_r + `WDTC_PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;                                              // [R9]
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;

endmodule : wdtc_prescaler

// *** design/wdtc_watchdog.sv ***
// Functional notes
// R1 - Counting chain advances only on low-power RC oscillator edges.
// R2 - Enabling the watchdog turns the low-power RC oscillator on.
// R3 - The RC oscillator runs nominally at 31 kHz.
// R4 - Prescaler divides by 32 or 128, chosen by one select bit.
// R5 - Prescaler period is about 1 ms or 4 ms at 31 kHz.
// R6 - Postscaler counts prescaler ticks before a timeout.
// R7 - Four-bit postscale select picks 16 ratios, 1:1 to 1:32768.
// R8 - Postscale code N gives ratio two to the power N.
// R9 - Device reset clears counter, prescaler and postscaler.
// R10 - Completed clock switch clears counter, prescaler and postscaler.
// R11 - Power-save instruction entering sleep or idle clears the chain.
// R12 - Leaving sleep or idle clears the chain again.
// R13 - Clear-watchdog instruction in normal operation clears the chain.
// R14 - Reaching the terminal count gives a one-cycle timeout pulse.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "wdtc_params.svh"

module wdtc_watchdog
  import wdtc_pkg::*;
#(
  parameter int unsigned MISS_CYCLES =
    (`WDTC_SYS_HZ * `WDTC_MISS_PERIODS + `WDTC_LOW_POWER_RC_OSC_HZ - 1)
    / `WDTC_LOW_POWER_RC_OSC_HZ
)
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Register port
  input  wire logic [`WDTC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`WDTC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [`WDTC_DATA_W-1:0]      reg_rdata_o,
  // Core events, one-cycle pulses on clk_sys_i
  input  wire logic                    clear_watchdog_instr_i,
  input  wire logic                    power_save_instr_i,
  input  wire logic                    wake_resume_i,
  input  wire logic                    osc_switch_done_i,
  // Oscillator
  input  wire logic                    low_power_rc_osc_i,
  output logic                         rc_osc_enable_o,
  // Result
  output logic                         timeout_o
);

  // Nominal timing, kept for reference and for the stall monitor
  localparam int unsigned LOW_POWER_RC_OSC_HZ      = `WDTC_LOW_POWER_RC_OSC_HZ;          // [R3]
  localparam int unsigned SYS_PER_RC   = `WDTC_SYS_HZ / LOW_POWER_RC_OSC_HZ;
  localparam int unsigned PRE_SHORT_US =
    (`WDTC_PRE_SHORT * 1000000) / LOW_POWER_RC_OSC_HZ;                       // [R5]
  localparam int unsigned PRE_LONG_US  =
    (`WDTC_PRE_LONG * 1000000) / LOW_POWER_RC_OSC_HZ;                        // [R5]
  localparam int unsigned MISS_W       = $clog2(MISS_CYCLES + 1);

  // Control register
  logic [`WDTC_CTRL_W-1:0] ctrl_r;
  logic [`WDTC_CTRL_W-1:0] ctrl_nxt;
  logic                    wd_enable;
  logic                    psa_long;
  logic [`WDTC_PS_W-1:0]   ps_sel;
  logic                    ctrl_wr;
  logic                    stat_wr;

  // RC oscillator synchroniser and edge detect
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic rc_rise;

  // Mode state
  wdtc_state_e state_r;
  wdtc_state_e state_nxt;

  // Chain control
  logic                    chain_clear;
  logic                    chain_adv;
  logic                    pre_tick;
  logic                    post_expire;
  logic [`WDTC_PRE_W-1:0]  pre_count;
  logic [`WDTC_POST_W-1:0] post_count;

  // Status and outputs
  logic                    timeout_r;
  logic                    timeout_nxt;
  logic                    to_flag_r;
  logic                    to_flag_nxt;
  logic                    stall_r;
  logic                    stall_nxt;
  logic [MISS_W-1:0]       miss_cnt_r;
  logic [MISS_W-1:0]       miss_cnt_nxt;
  logic [`WDTC_DATA_W-1:0] rdata_r;
  logic [`WDTC_DATA_W-1:0] rdata_nxt;

  // Exact byte-address match; partial decode would alias registers
  function automatic logic reg_hit(
    input logic [`WDTC_ADDR_W-1:0] addr,
    input logic [`WDTC_ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction : reg_hit

  assign wd_enable = ctrl_r[`WDTC_CTRL_EN];
  assign psa_long  = ctrl_r[`WDTC_CTRL_PSA];
  assign ps_sel    = ctrl_r[`WDTC_CTRL_PS_MSB:`WDTC_CTRL_PS_LSB];

  // Write decode shared by the control and status paths
  assign ctrl_wr = reg_wr_i && reg_hit(reg_addr_i, `WDTC_OFF_CTRL);
  assign stat_wr = reg_wr_i && reg_hit(reg_addr_i, `WDTC_OFF_STATUS);

  // Enabled watchdog forces its RC source on
  assign rc_osc_enable_o = wd_enable;                            // [R2]

  // Control register write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt = reg_wdata_i[`WDTC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `WDTC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // The RC clock is foreign to clk_sys_i; only sync2 onward is looked at
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= low_power_rc_osc_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign rc_rise = sync2_r && !sync3_r;

  // Mode tracking: off, running, sleeping or idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WDTC_OFF: begin
        if (wd_enable) begin
          state_nxt = WDTC_RUN;
        end
      end
      WDTC_RUN: begin
        if (!wd_enable) begin
          state_nxt = WDTC_OFF;
        end else if (power_save_instr_i) begin
          state_nxt = WDTC_SLEEP;
        end
      end
      WDTC_SLEEP: begin
        if (!wd_enable) begin
          state_nxt = WDTC_OFF;
        end else if (wake_resume_i) begin
          state_nxt = WDTC_RUN;
        end
      end
      default: begin
        state_nxt = WDTC_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= WDTC_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clear sources; a clear beats an advance in the same cycle
  always_comb begin
    chain_clear = 1'b0;
    if (state_r == WDTC_OFF) begin
      chain_clear = 1'b1;
    end
    // Disable acts in its own cycle, before the mode catches up
    if (!wd_enable) begin
      chain_clear = 1'b1;                                        // [R2]
    end
    if (osc_switch_done_i) begin
      chain_clear = 1'b1;                                        // [R10]
    end
    if ((state_r == WDTC_RUN) && power_save_instr_i) begin
      chain_clear = 1'b1;                                        // [R11]
    end
    if ((state_r == WDTC_SLEEP) && wake_resume_i) begin
      chain_clear = 1'b1;                                        // [R12]
    end
    if ((state_r == WDTC_RUN) && clear_watchdog_instr_i) begin
      chain_clear = 1'b1;                                        // [R13]
    end
  end

  // System clock only samples; steps come from RC edges alone
  assign chain_adv = rc_rise && (state_r != WDTC_OFF);           // [R1]

  wdtc_prescaler u_pre (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .advance_i  (chain_adv),
    .clear_i    (chain_clear),
    .long_sel_i (psa_long),
    .tick_o     (pre_tick),
    .count_o    (pre_count)
  );                                                             // [R4]

  wdtc_postscaler u_post (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .advance_i  (pre_tick),
    .clear_i    (chain_clear),
    .sel_i      (ps_sel),
    .expire_o   (post_expire),
    .count_o    (post_count)
  );                                                             // [R6]

  // Timeout pulse, sticky flag and RC stall monitor
  always_comb begin
    timeout_nxt  = post_expire;                                  // [R14]
    to_flag_nxt  = to_flag_r;
    if (stat_wr && reg_wdata_i[`WDTC_STAT_TIMEOUT]) begin
      to_flag_nxt = 1'b0;
    end
    // A timeout in the clearing cycle is kept
    if (post_expire) begin
      to_flag_nxt = 1'b1;
    end
  end

  // Stall watch: a dead RC source would leave the watchdog toothless
  always_comb begin
    stall_nxt    = stall_r;
    miss_cnt_nxt = miss_cnt_r;
    if (!wd_enable || rc_rise) begin
      miss_cnt_nxt = '0;
      stall_nxt    = 1'b0;
    end else if (miss_cnt_r >= MISS_W'(MISS_CYCLES)) begin
      stall_nxt    = 1'b1;
    end else begin
      miss_cnt_nxt = miss_cnt_r + MISS_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_r  <= 1'b0;
      to_flag_r  <= 1'b0;
    end else begin
      timeout_r  <= timeout_nxt;
      to_flag_r  <= to_flag_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stall_r    <= 1'b0;
      miss_cnt_r <= '0;
    end else begin
      stall_r    <= stall_nxt;
      miss_cnt_r <= miss_cnt_nxt;
    end
  end

  assign timeout_o = timeout_r;

  // Read data stand for the one cycle after the strobe, zero elsewhere
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      if (reg_hit(reg_addr_i, `WDTC_OFF_CTRL)) begin
        rdata_nxt[`WDTC_CTRL_W-1:0] = ctrl_r;
      end else if (reg_hit(reg_addr_i, `WDTC_OFF_STATUS)) begin
        rdata_nxt[`WDTC_STAT_TIMEOUT]  = to_flag_r;
        rdata_nxt[`WDTC_STAT_RC_STALL] = stall_r;
        rdata_nxt[`WDTC_STAT_RUNNING]  = (state_r == WDTC_RUN);
        rdata_nxt[`WDTC_STAT_SLEEP]    = (state_r == WDTC_SLEEP);
      end else if (reg_hit(reg_addr_i, `WDTC_OFF_PRE_COUNT)) begin
        rdata_nxt[`WDTC_PRE_W-1:0] = pre_count;
      end else if (reg_hit(reg_addr_i, `WDTC_OFF_POST_COUNT)) begin
        rdata_nxt[`WDTC_POST_W-1:0] = post_count;
      end else if (reg_hit(reg_addr_i, `WDTC_OFF_POST_TERM)) begin
        rdata_nxt[`WDTC_POST_W-1:0] = wdtc_post_limit(ps_sel);   // [R8]
      end else begin
        rdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : wdtc_watchdog
